// file: src/pwae_pkg.sv
// Constants, register map and carrier types of the pulse width approach
// engine. Assumes a 32-bit APB with byte addresses and one clock domain.
//
// Functional notes
// - Target above width: step width upward
// - Upward overshoot by full step, then snap
// - Target below width: step width downward
// - Downward overshoot by full step, then snap
// - Clamp result to 511 or 0
// - Code 10B: three triggers; 011B: four units
// - Count and step adjust every adjust_interval+1 triggers
// - Readable phase indicator: 01 first, 10 second
// - Reached flags set on equality in interval
// - Software clears flags; restart clears the two reached flags, not done
// - First interval holds width; approach starts after
package pwae_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WIDTH = 8'h04;
  localparam logic [7:0] ADDR_FIRST = 8'h08;
  localparam logic [7:0] ADDR_SECOND = 8'h0C;
  localparam logic [7:0] ADDR_STEPCFG = 8'h10;
  localparam logic [7:0] ADDR_TIMER = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_MASK = 8'h1C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_HW_BIT = 0;
  localparam int CTRL_EN_BIT = 1;
  localparam int CTRL_SEL2_BIT = 2;
  localparam int CTRL_RSS_BIT = 3;
  localparam int CTRL_RUN_BIT = 4;
  localparam int CTRL_PSC_LSB = 5;
  localparam int STAT_PHASE_LSB = 4;
  localparam int TMR_PSC_LSB = 24;

  // ---------------------------------------------------------------
  // Widths, limits and reset values
  // ---------------------------------------------------------------
  localparam int WW = 9;
  localparam int TW = 8;
  localparam int DIVW = 3;
  localparam logic [WW-1:0] WIDTH_MAX = 9'h1FF;
  localparam logic [WW-1:0] WIDTH_MIN = 9'h000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [11:0] STEPCFG_RST = 12'h000;
  localparam logic [25:0] TIMER_RST = 26'h000_0000;
  localparam logic [2:0] MASK_RST = 3'h0;

  // Adjust codes: 00 and 11 leave the value alone
  localparam logic [1:0] ADJ_DEC = 2'b01;
  localparam logic [1:0] ADJ_INC = 2'b10;

  // Interrupt status bits
  localparam int EV_FIRST = 0;
  localparam int EV_SECOND = 1;
  localparam int EV_DONE = 2;

  // Phase codes double as the phase indicator value
  typedef enum logic [1:0] {
    PH_HOLD = 2'b00,
    PH_FIRST = 2'b01,
    PH_SECOND = 2'b10,
    PH_IDLE = 2'b11
  } pwae_phase_t;

  // Step settings as laid out in the step configuration register
  typedef struct packed {
    logic [1:0] step_adjust;
    logic [1:0] count_adjust;
    logic [2:0] adjust_interval;
    logic [2:0] step_size;
    logic [1:0] triggers_per_step;
  } pwae_step_cfg_t;

endpackage : pwae_pkg

// file: src/pwae_phase_timer.sv
// Phase timer: prescaled up-counter that reports overflow.
// Assumes load and run come from the engine on the same clock.
`timescale 1ns/10ps
module pwae_phase_timer
  import pwae_pkg::*;
#(
  parameter int CW = pwae_pkg::TW
)
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic run_in,
  input wire logic [CW-1:0] load_val_in,
  input wire logic [1:0] psc_in,
  output logic ovf_out
);
  logic [CW-1:0] cnt_r;
  logic [DIVW-1:0] div_r;
  logic [DIVW-1:0] div_mask;
  logic tick;

  // ---------------------------------------------------------------
  // Prescaler: divide by 1, 2, 4 or 8 as a one-cycle enable
  // ---------------------------------------------------------------
  assign div_mask = DIVW'((1 << psc_in) - 1);
  assign tick = run_in && ((div_r & div_mask) == div_mask);
  assign ovf_out = tick && (cnt_r == {CW{1'b1}});

  // Load restarts the divider so each interval has full length
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_r <= '0;
      div_r <= '0;
    end
    else if (load_in)
    begin
      cnt_r <= load_val_in;
      div_r <= '0;
    end
    else if (run_in)
    begin
      div_r <= div_r + 1'b1;
      if (tick)
        cnt_r <= cnt_r + 1'b1;
    end
  end

endmodule : pwae_phase_timer

// file: src/pwae_stepper.sv
// Width stepper: next width for one move toward a target.
// Assumes the caller only moves when width and target differ.
`timescale 1ns/10ps
module pwae_stepper
  import pwae_pkg::*;
(
  input wire logic [WW-1:0] width_in,
  input wire logic [WW-1:0] target_in,
  input wire logic [3:0] step_in,
  output logic [WW-1:0] next_out,
  output logic overshoot_out
);
  logic up;
  logic [WW:0] sum;
  logic [WW-1:0] up_val;
  logic [WW-1:0] dn_val;

  // ---------------------------------------------------------------
  // Full step each way, clamped at the ends of the 9-bit range
  // ---------------------------------------------------------------
  assign up = target_in > width_in;
  assign sum = {1'b0, width_in} + {6'h00, step_in};
  assign up_val = sum[WW] ? WIDTH_MAX : sum[WW-1:0];
  assign dn_val = (width_in < {5'h00, step_in}) ? WIDTH_MIN
                : width_in - {5'h00, step_in};
  assign next_out = up ? up_val : dn_val;
  // Passing the target is not avoided; the caller snaps back later
  assign overshoot_out = up ? (up_val > target_in)
                       : (dn_val < target_in);

endmodule : pwae_stepper

// file: src/pwae_engine.sv
// Pulse width approach engine with APB register access.
// Assumes trigger and comparator inputs are synchronous to core_clk_in.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps
module pwae_engine
  import pwae_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pulse_trigger_in,
  input wire logic restart_comparator_output_in,
  output logic [pwae_pkg::WW-1:0] active_width_out,
  output logic [1:0] phase_indicator_out,
  output logic phase_timer_run_out,
  output logic irq_out
);
  import pwae_pkg::*;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic hw_mode_r;
  logic approach_en_r;
  logic sw_sel2_r;
  logic rss_r;
  logic [WW-1:0] width_r;
  logic [WW-1:0] first_r;
  logic [WW-1:0] second_r;
  pwae_step_cfg_t cfg_r;
  logic [3*TW-1:0] reload_r;
  logic [1:0] psc_r;
  logic [2:0] stat_r;
  logic [2:0] stat_nxt;
  logic [2:0] mask_r;
  logic [31:0] prdata_r;
  logic slverr_r;
  logic cmp_q_r;
  pwae_phase_t ph_r;
  pwae_phase_t ph_nxt;
  logic [1:0] cnt_w_r;
  logic [2:0] step_w_r;
  logic [1:0] trig_cnt_r;
  logic [2:0] adj_cnt_r;
  logic snap_r;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic wr_ctrl;
  logic wr_width;
  logic wr_targets;
  logic wr_stat;
  logic [31:0] rd_mux;

  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= ADDR_MASK);
  assign wr_ctrl = wr_acc && (paddr == ADDR_CTRL);
  assign wr_stat = wr_acc && (paddr == ADDR_STATUS);
  assign wr_width = wr_acc && (paddr == ADDR_WIDTH);
  // Targets, step and timer settings are locked while a run is in progress
  assign wr_targets = wr_acc && (ph_r == PH_IDLE);
  assign pready = 1'b1;
  assign pslverr = slverr_r;
  assign prdata = prdata_r;

  // Read data multiplexer
  assign rd_mux =
      (paddr == ADDR_CTRL) ? {25'h000_0000, psc_r, phase_timer_run_out,
                              rss_r, sw_sel2_r, approach_en_r, hw_mode_r}
    : (paddr == ADDR_WIDTH) ? {23'h00_0000, width_r}
    : (paddr == ADDR_FIRST) ? {23'h00_0000, first_r}
    : (paddr == ADDR_SECOND) ? {23'h00_0000, second_r}
    : (paddr == ADDR_STEPCFG) ? {20'h0_0000, cfg_r}
    : (paddr == ADDR_TIMER) ? {6'h00, psc_r, reload_r}
    : (paddr == ADDR_STATUS) ? {26'h000_0000, ph_r, 1'b0, stat_r}
    : (paddr == ADDR_MASK) ? {29'h0000_0000, mask_r}
    : 32'h0000_0000;

  // Read data is captured in the setup cycle; zero-wait access phase
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end
    else if (rd_setup)
    begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      slverr_r <= !mapped;
    end
  end

  // ---------------------------------------------------------------
  // Restart sources
  // ---------------------------------------------------------------
  logic cmp_rise;
  logic sw_start;
  logic start;
  logic restart_any;

  assign cmp_rise = restart_comparator_output_in && !cmp_q_r;
  // Writing run as 1 while stopped is the software restart
  assign sw_start = wr_ctrl && pwdata[CTRL_RUN_BIT] && hw_mode_r
                  && pwdata[CTRL_HW_BIT] && !phase_timer_run_out;
  assign start = hw_mode_r && (rss_r ? sw_start : cmp_rise);
  assign restart_any = hw_mode_r && (cmp_rise || sw_start);

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      cmp_q_r <= 1'b0;
    else
      cmp_q_r <= restart_comparator_output_in;
  end

  // ---------------------------------------------------------------
  // Phase sequencing
  // ---------------------------------------------------------------
  logic ovf;
  logic tmr_load;
  logic [TW-1:0] tmr_val;

  pwae_phase_timer #(
    .CW(TW)
  ) u_timer (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .load_in(tmr_load),
    .run_in(phase_timer_run_out),
    .load_val_in(tmr_val),
    .psc_in(psc_r),
    .ovf_out(ovf)
  );

  assign phase_timer_run_out = (ph_r != PH_IDLE);
  assign phase_indicator_out = ph_r;
  assign tmr_load = start || (ovf && ph_r != PH_SECOND);
  assign tmr_val = start ? reload_r[TW-1:0]
                 : (ph_r == PH_HOLD) ? reload_r[2*TW-1:TW]
                 : reload_r[3*TW-1:2*TW];

  // Overflow moves to the next interval; a restart begins anew
  always_comb
  begin
    ph_nxt = ph_r;
    if (!hw_mode_r)
      ph_nxt = PH_IDLE;
    else if (start)
      ph_nxt = PH_HOLD;
    else if (ovf)
    begin
      unique case (ph_r)
        PH_HOLD: ph_nxt = PH_FIRST;
        PH_FIRST: ph_nxt = PH_SECOND;
        PH_SECOND: ph_nxt = PH_IDLE;
        PH_IDLE: ph_nxt = PH_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Approach control
  // ---------------------------------------------------------------
  logic approaching;
  logic [WW-1:0] target;
  logic at_target;
  logic trig;
  logic move;
  logic adjust;
  logic [WW-1:0] step_next;
  logic step_over;

  // In hardware mode hold interval and idle are not approaching, so width stays put
  assign approaching = hw_mode_r
                     ? (ph_r == PH_FIRST || ph_r == PH_SECOND)
                     : approach_en_r;
  assign target = (hw_mode_r ? (ph_r == PH_SECOND) : sw_sel2_r)
                ? second_r : first_r;
  assign at_target = (width_r == target);
  assign trig = pulse_trigger_in && approaching;
  // Move once per triggers_per_step+1 triggers; none at target.
  // At or past the count, so a lowered count need not wait for a wrap
  assign move = trig && !snap_r && !at_target
              && (trig_cnt_r >= cnt_w_r);
  assign adjust = trig && (adj_cnt_r == cfg_r.adjust_interval);

  pwae_stepper u_stepper (
    .width_in(width_r),
    .target_in(target),
    .step_in({1'b0, step_w_r} + 4'h1),
    .next_out(step_next),
    .overshoot_out(step_over)
  );

  // Saturating adjust of a 3-bit code
  function automatic logic [2:0] adj_code(input logic [2:0] v,
                                          input logic [1:0] how,
                                          input logic [2:0] top);
    adj_code = v;
    if (how == ADJ_INC && v != top)
      adj_code = v + 3'h1;
    else if (how == ADJ_DEC && v != 3'h0)
      adj_code = v - 3'h1;
  endfunction : adj_code

  // Working copies reload from the registers whenever not approaching and on each phase change
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_w_r <= 2'h0;
      step_w_r <= 3'h0;
      trig_cnt_r <= 2'h0;
      adj_cnt_r <= 3'h0;
      snap_r <= 1'b0;
    end
    else if (!approaching || ph_nxt != ph_r)
    begin
      cnt_w_r <= cfg_r.triggers_per_step;
      step_w_r <= cfg_r.step_size;
      trig_cnt_r <= 2'h0;
      adj_cnt_r <= 3'h0;
      snap_r <= 1'b0;
    end
    else if (trig)
    begin
      trig_cnt_r <= (move || snap_r) ? 2'h0 : trig_cnt_r + 2'h1;
      snap_r <= move && step_over;
      adj_cnt_r <= adjust ? 3'h0 : adj_cnt_r + 3'h1;
      if (adjust)
      begin
        cnt_w_r <= 2'(adj_code({1'b0, cnt_w_r}, cfg_r.count_adjust,
                               3'h3));
        step_w_r <= adj_code(step_w_r, cfg_r.step_adjust, 3'h7);
      end
    end
  end

  // ---------------------------------------------------------------
  // Width and settings registers
  // ---------------------------------------------------------------
  assign active_width_out = width_r;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      width_r <= WIDTH_MIN;
    else if (trig && snap_r)
      width_r <= target;
    else if (move)
      width_r <= step_next;
    else if (wr_width && !approaching && ph_r == PH_IDLE)
      width_r <= pwdata[WW-1:0];
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      first_r <= WIDTH_MIN;
      second_r <= WIDTH_MIN;
      cfg_r <= STEPCFG_RST;
      reload_r <= TIMER_RST[3*TW-1:0];
      psc_r <= TIMER_RST[TMR_PSC_LSB +: 2];
      mask_r <= MASK_RST;
    end
    else
    begin
      if (wr_targets && paddr == ADDR_FIRST)
        first_r <= pwdata[WW-1:0];
      if (wr_targets && paddr == ADDR_SECOND)
        second_r <= pwdata[WW-1:0];
      if (wr_targets && paddr == ADDR_STEPCFG)
        cfg_r <= pwdata[11:0];
      if (wr_targets && paddr == ADDR_TIMER)
      begin
        reload_r <= pwdata[3*TW-1:0];
        psc_r <= pwdata[TMR_PSC_LSB +: 2];
      end
      if (wr_acc && paddr == ADDR_MASK)
        mask_r <= pwdata[2:0];
    end
  end

  // Control bits and phase state
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      hw_mode_r <= CTRL_RST[CTRL_HW_BIT];
      approach_en_r <= CTRL_RST[CTRL_EN_BIT];
      sw_sel2_r <= CTRL_RST[CTRL_SEL2_BIT];
      rss_r <= CTRL_RST[CTRL_RSS_BIT];
      ph_r <= PH_IDLE;
    end
    else
    begin
      ph_r <= ph_nxt;
      if (wr_ctrl)
      begin
        hw_mode_r <= pwdata[CTRL_HW_BIT];
        approach_en_r <= pwdata[CTRL_EN_BIT];
        sw_sel2_r <= pwdata[CTRL_SEL2_BIT];
        rss_r <= pwdata[CTRL_RSS_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Reached flags and interrupt
  // ---------------------------------------------------------------
  logic [2:0] ev_set;
  logic [2:0] hw_clr;

  assign ev_set[EV_FIRST] = (ph_r == PH_FIRST) && at_target;
  assign ev_set[EV_SECOND] = (ph_r == PH_SECOND) && at_target;
  assign ev_set[EV_DONE] = ovf && (ph_r == PH_SECOND);
  assign hw_clr = restart_any ? 3'b011 : 3'b000;
  // Software can only clear; a same-cycle event still sets
  assign stat_nxt = (stat_r & ~hw_clr
                  & ~(wr_stat ? pwdata[2:0] : 3'b000)) | ev_set;
  assign irq_out = |(stat_r & mask_r);

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      stat_r <= 3'b000;
    else
      stat_r <= stat_nxt;
  end

endmodule : pwae_engine

// file: verification/pwae_checker.sv
// Port checker for the approach engine, bound to its top module.
// Assumes one core clock and an active-high asynchronous reset.
`timescale 1ns/10ps
module pwae_checker
  import pwae_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pulse_trigger_in,
  input wire logic [pwae_pkg::WW-1:0] active_width_out,
  input wire logic [1:0] phase_indicator_out,
  input wire logic phase_timer_run_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  logic [WW-1:0] prev_w_r;
  // Last width, so a move size can be judged without $past arithmetic
  always_ff @(posedge core_clk_in)
    prev_w_r <= active_width_out;
  wire logic [WW-1:0] w_diff = (active_width_out > prev_w_r) ?
    active_width_out - prev_w_r : prev_w_r - active_width_out;
  wire logic bad_addr = paddr > 8'h1C || paddr[1:0] != 2'b00;
  wire logic wr_acc = psel && penable && pwrite;
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  apb_answer_a: assert property (setup_s |=> access_s)
    else $error("APB access phase not answered");
  bad_addr_a: assert property (psel && !penable && bad_addr |=> pslverr)
    else $error("Unmapped access without error");
  good_addr_a: assert property (psel && !penable && !bad_addr |=> !pslverr)
    else $error("Mapped access flagged as error");
  reset_idle_a: assert property ($fell(rst_in) |->
    phase_indicator_out == PH_IDLE && active_width_out == WIDTH_MIN)
    else $error("Wrong state after reset");
  run_decode_a: assert property (
    phase_timer_run_out == (phase_indicator_out != PH_IDLE) &&
    (!$rose(phase_timer_run_out) || phase_indicator_out == PH_HOLD))
    else $error("Run flag disagrees with phase");
  phase_order_a: assert property ($changed(phase_indicator_out) |->
    phase_indicator_out == $past(phase_indicator_out) + 2'b01 ||
    phase_indicator_out == PH_HOLD || phase_indicator_out == PH_IDLE)
    else $error("Phase skipped a step");
  hold_width_a: assert property (phase_indicator_out == PH_HOLD &&
    $past(phase_indicator_out) == PH_HOLD |-> $stable(active_width_out))
    else $error("Width moved in hold interval");
  move_cause_a: assert property ($changed(active_width_out) |->
    $past(pulse_trigger_in) || $past(wr_acc))
    else $error("Width moved without trigger");
  step_bound_a: assert property ($changed(active_width_out) &&
    !$past(wr_acc) |-> w_diff <= 9'h008)
    else $error("Width moved by more than a step");
endmodule : pwae_checker

bind pwae_engine pwae_checker u_chk (.core_clk_in, .rst_in, .psel,
  .penable, .pwrite, .paddr, .pready, .pslverr, .pulse_trigger_in,
  .active_width_out, .phase_indicator_out, .phase_timer_run_out);

// file: verification/pwae_drive_model.sv
// Far-side model: pulse trigger source and comparator output.
// Assumes bench requests arrive on the core clock.
`timescale 1ns/10ps
module pwae_drive_model
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic trig_en_in,
  input wire logic [3:0] gap_in,
  input wire logic cmp_req_in,
  output logic pulse_trigger_out,
  output logic comparator_out
);
  logic [3:0] gap_cnt_r;
  // One-cycle pulses gap_in+1 cycles apart; gap_in of 0 is never used
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      gap_cnt_r <= 4'h0;
      pulse_trigger_out <= 1'b0;
      comparator_out <= 1'b0;
    end
    else
    begin
      pulse_trigger_out <= trig_en_in && gap_cnt_r == gap_in;
      gap_cnt_r <= (!trig_en_in || gap_cnt_r == gap_in) ? 4'h0 :
        gap_cnt_r + 4'h1;
      comparator_out <= cmp_req_in;
    end
  end
endmodule : pwae_drive_model

// file: verification/pwae_engine_test.sv
// Self-checking bench for the approach engine with a reference model.
// Assumes the drive model supplies triggers and the comparator level.
`timescale 1ns/10ps
module pwae_engine_test;
  import pwae_pkg::*;
  logic core_clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, trig, cmp, irq_out, run_out, err;
  logic trig_en = 0, cmp_req = 0;
  logic [3:0] gap = 4'h3;
  logic [WW-1:0] width;
  logic [1:0] phase;
  int failures = 0, cmp_count = 0, seed = 36;
  int m_w, m_t, m_cc, m_sc, m_iv, m_ca, m_sa, m_mv, m_ac, m_over;
  pwae_step_cfg_t cfg;
  pwae_engine u_dut (.core_clk_in, .rst_in, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pulse_trigger_in(trig),
    .restart_comparator_output_in(cmp), .active_width_out(width),
    .phase_indicator_out(phase), .phase_timer_run_out(run_out), .irq_out);
  pwae_drive_model u_far (.core_clk_in, .rst_in, .trig_en_in(trig_en),
    .gap_in(gap), .cmp_req_in(cmp_req), .pulse_trigger_out(trig),
    .comparator_out(cmp));
  // 250 MHz core clock
  initial
  begin
    forever #2 core_clk_in = ~core_clk_in;
  end
  // Watchdog: the whole run needs well under 20000 cycles
  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    failures++;
    complete_run();
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("Compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; holds the request until pready is seen high
  task automatic xfer(input logic [7:0] a, input logic w,
    input logic [31:0] d);
    @(posedge core_clk_in);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    // No timeout here; if pready stays low, only the watchdog ends this wait
    do
      @(posedge core_clk_in);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdc
  task automatic wait_phase(input logic [1:0] p);
    int n;
    n = 0;
    while (phase !== p && n < 3000)
    begin
      @(posedge core_clk_in);
      n++;
    end
    chk({30'h0, phase}, {30'h0, p});
  endtask : wait_phase
  // Reference stepper, one call per accepted trigger
  task automatic model_trig();
    bit up;
    up = m_t > m_w;
    if (m_over != 0)
    begin
      m_w = m_t;
      m_over = 0;
    end
    else if (m_w != m_t && ++m_mv > m_cc)
    begin
      m_mv = 0;
      if (up)
        m_w = (m_w + m_sc + 1 > 511) ? 511 : m_w + m_sc + 1;
      else
        m_w = (m_w - m_sc - 1 < 0) ? 0 : m_w - m_sc - 1;
      m_over = up ? m_w > m_t : m_w < m_t;
    end
    if (++m_ac > m_iv)
    begin
      m_ac = 0;
      m_cc += (m_ca == 2 && m_cc < 3) - (m_ca == 1 && m_cc > 0);
      m_sc += (m_sa == 2 && m_sc < 7) - (m_sa == 1 && m_sc > 0);
    end
  endtask : model_trig
  // Software-mode approach compared with the model after every trigger
  task automatic sw_run(input int w0, input int t, input logic [11:0] c,
    input logic sel, input int nt);
    xfer(ADDR_CTRL, 1'b1, 32'h0000_0000);
    xfer(ADDR_WIDTH, 1'b1, 32'(w0));
    xfer(ADDR_FIRST, 1'b1, 32'(t));
    xfer(ADDR_SECOND, 1'b1, 32'(511 - t));
    xfer(ADDR_STEPCFG, 1'b1, {20'h0_0000, c});
    cfg = c;
    m_w = w0;
    m_t = sel ? 511 - t : t;
    m_cc = cfg.triggers_per_step;
    m_sc = cfg.step_size;
    m_iv = cfg.adjust_interval;
    m_ca = cfg.count_adjust;
    m_sa = cfg.step_adjust;
    m_mv = 0;
    m_ac = 0;
    m_over = 0;
    xfer(ADDR_CTRL, 1'b1, {29'h0, sel, 2'b10});
    trig_en <= 1'b1;
    repeat (nt)
    begin
      do @(posedge core_clk_in); while (trig !== 1'b1);
      model_trig();
      @(negedge core_clk_in);
      chk({23'h0, width}, 32'(m_w));
    end
    @(posedge core_clk_in);
    trig_en <= 1'b0;
  endtask : sw_run
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge core_clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < 8; i++)
      rdc(8'(i * 4), (i == 6) ? 32'h0000_0030 : 32'h0000_0000);
    xfer(8'h20, 1'b0, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    xfer(8'h02, 1'b1, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    sw_run(400, 420, 12'h22E, 1'b0, 24);
    sw_run(509, 511, 12'h01C, 1'b0, 3);
    sw_run(3, 1, 12'h00C, 1'b0, 3);
    sw_run(420, 101, 12'h00C, 1'b1, 6);
    sw_run(100, 200, 12'h903, 1'b0, 20);
    for (int i = 0; i < 6; i++)
    begin
      gap <= 4'(($random(seed) & 7) | 1);
      sw_run($random(seed) & 511, $random(seed) & 511,
        12'($random(seed)), i[0], 30);
    end
    gap <= 4'h3;
    xfer(ADDR_CTRL, 1'b1, 32'h0000_0000);
    xfer(ADDR_WIDTH, 1'b1, 32'h0000_0190);
    xfer(ADDR_FIRST, 1'b1, 32'h0000_01A4);
    xfer(ADDR_SECOND, 1'b1, 32'h0000_019A);
    xfer(ADDR_STEPCFG, 1'b1, 32'h0000_022E);
    xfer(ADDR_TIMER, 1'b1, 32'h0000_00F0);
    xfer(ADDR_MASK, 1'b1, 32'h0000_0000);
    xfer(ADDR_CTRL, 1'b1, 32'h0000_0001);
    trig_en <= 1'b1;
    cmp_req <= 1'b1;
    wait_phase(PH_HOLD);
    wait_phase(PH_FIRST);
    chk({23'h0, width}, 32'h0000_0190);
    chk({31'h0, run_out}, 32'h0000_0001);
    wait_phase(PH_SECOND);
    chk({23'h0, width}, 32'h0000_01A4);
    chk({31'h0, irq_out}, 32'h0000_0000);
    xfer(ADDR_FIRST, 1'b1, 32'h0000_0055);
    xfer(ADDR_MASK, 1'b1, 32'h0000_0001);
    // Mask lands at the access edge; look once it has settled
    @(negedge core_clk_in);
    chk({31'h0, irq_out}, 32'h0000_0001);
    wait_phase(PH_IDLE);
    chk({23'h0, width}, 32'h0000_019A);
    chk({31'h0, run_out}, 32'h0000_0000);
    rdc(ADDR_STATUS, 32'h0000_0037);
    rdc(ADDR_FIRST, 32'h0000_01A4);
    repeat (2) xfer(ADDR_STATUS, 1'b1, 32'h0000_0001);
    rdc(ADDR_STATUS, 32'h0000_0036);
    chk({31'h0, irq_out}, 32'h0000_0000);
    // Second run: prescaler of two, software restart source first
    xfer(ADDR_TIMER, 1'b1, 32'h0100_00F0);
    xfer(ADDR_CTRL, 1'b1, 32'h0000_0009);
    xfer(ADDR_CTRL, 1'b1, 32'h0000_0019);
    rdc(ADDR_STATUS, 32'h0000_0004);
    wait_phase(PH_IDLE);
    chk({23'h0, width}, 32'h0000_019A);
    rdc(ADDR_STATUS, 32'h0000_0037);
    cmp_req <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    cmp_req <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    xfer(ADDR_STATUS, 1'b0, 32'h0000_0000);
    chk(rd & 32'h0000_0003, 32'h0000_0000);
    complete_run();
  end
endmodule : pwae_engine_test
